// ### rtl/swm_pkg.sv
// Shared constants and types for the single-wire bus master.
// Assumes a 25 MHz system clock; all times are in microseconds except OD_RD_SAMPLE_CYC and REC_CYC, which are in clock cycles.
package swm_pkg;
	localparam int CLK_MHZ = 25;
	// Regular speed times.
	localparam int RST_LOW_US   = 480;
	localparam int RST_HIGH_US  = 480;
	localparam int SLOT_US      = 70;
	localparam int W1_LOW_US    = 6;
	localparam int W0_LOW_US    = 64;
	localparam int RD_LOW_US    = 2;
	localparam int RD_SAMPLE_US = 12;
	localparam int REC_US       = 2;
	localparam int PRES_WIN_US  = 70;
	// Overdrive speed times; presence sampled inside the short window.
	localparam int OD_RST_LOW_US   = 64;
	localparam int OD_RST_HIGH_US  = 48;
	localparam int OD_SLOT_US      = 10;
	localparam int OD_W1_LOW_US    = 1;
	localparam int OD_W0_LOW_US    = 8;
	localparam int OD_RD_LOW_US    = 1;
	// Overdrive read sample is in cycles from the falling edge. Whole microseconds cannot land
	// between release plus synchroniser lag and the end of valid data.
	localparam int OD_RD_SAMPLE_CYC = 38;
	localparam int OD_PRES_WIN_US  = 8;
	localparam int REC_CYC = REC_US * CLK_MHZ;
	localparam logic [1:0] CMD_RESET = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_READ  = 2'h2;
	localparam logic [1:0] CMD_SPEED = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOW  = 3'h1,
		ST_HIGH = 3'h3,
		ST_REC  = 3'h2
	} swm_state_t;
endpackage : swm_pkg

// ### rtl/swm_buf_if.sv
// Valid and ready handshake carrying one result word between modules.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface swm_buf_if #(parameter int W = 2);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : swm_buf_if

// ### rtl/swm_skid.sv
// Two-entry buffer between the slot engine and the result consumer.
// Assumes both sides are on clk; downstream may stall indefinitely.
`timescale 1ns/1ps
module swm_skid #(
	parameter int W = 2
) (
	input  wire logic clk,
	input  wire logic rst_b,
	swm_buf_if.snk    inp,
	swm_buf_if.src    outp
);
	logic [W-1:0] mem_q [2];
	logic         wr_q;
	logic         rd_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	assign inp.ready  = (cnt_q != 2'h2);
	assign outp.valid = (cnt_q != 2'h0);
	assign outp.data  = mem_q[rd_q];
	assign push = inp.valid & inp.ready;
	assign pop  = outp.valid & outp.ready;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 2'h0;
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
			if (push) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
		end
	end

	always_ff @(posedge clk) begin
		if (push) mem_q[wr_q] <= inp.data;
	end

	a_skid_no_over: assert property (@(posedge clk) disable iff (!rst_b)
		cnt_q != 2'h2 || !inp.valid) else $error("Buffer written while full.");
endmodule : swm_skid

// ### rtl/swm_master.sv
// Single-wire bus master: reset/presence, write and read slots, two speeds.
// Assumes an external pull-up and that the line pin is driven low only via lineOe.
// Contract
// - Master begins each slot by pulling low; at least 1 us released between slots.
// - With overdrive set, both ends use overdrive slot timing.
// - Regular slots 60-120 us; one low 1-15 us; zero low 60-120 us.
// - Overdrive slots 6-16 us; one low 1-2; zero 6-16; reset 48-80 us.
// - Regular reset low at least 480 us, keep under 960 us.
// - Master waits 480 us (48 us overdrive) high after reset.
// - Master read low 1-15 us (1-2 overdrive), samples before valid window ends.
// - Identity sequence after overdrive match always goes at overdrive speed.
// - Suspended master leaves the line high; long lows reset slaves.
`timescale 1ns/1ps
module swm_master #(
	parameter int RST_LOW_CYC  = swm_pkg::RST_LOW_US * swm_pkg::CLK_MHZ,
	parameter int RST_HIGH_CYC = swm_pkg::RST_HIGH_US * swm_pkg::CLK_MHZ
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       cmdValid,
	output wire logic       cmdReady,
	input  wire logic [1:0] cmdOp,
	input  wire logic       cmdBit,
	output wire logic       rspValid,
	input  wire logic       rspReady,
	output wire logic       rspBit,
	output wire logic       rspPresence,
	output wire logic       overdrive,
	input  wire logic       lineIn,
	output wire logic       lineOut,
	output wire logic       lineOe
);
	function automatic logic [15:0] cyc(input int us);
		return 16'(us * swm_pkg::CLK_MHZ);
	endfunction : cyc

	swm_buf_if #(.W(2)) toBuf ();
	swm_buf_if #(.W(2)) fromBuf ();

	swm_pkg::swm_state_t state_q;
	logic [15:0] cnt_q;
	logic [15:0] lowLen_q;
	logic [15:0] slotLen_q;
	logic [15:0] sampleAt_q;
	logic        isReset_q;
	logic        doSample_q;
	logic        sampled_q;
	logic        overdrive_q;
	logic        resVld_q;
	logic [1:0]  resData_q;
	logic [2:0]  sync_q;
	logic        lineS_q;
	logic        take;
	logic [15:0] lowRun_q;

	// Three-stage synchroniser; a change counts once stages two and three agree.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_q  <= 3'h7;
			lineS_q <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], lineIn};
			if (sync_q[1] == sync_q[2]) lineS_q <= sync_q[2];
		end
	end

	// Commands stall while the engine is busy or the result buffer is full.
	assign take     = cmdValid && state_q == swm_pkg::ST_IDLE && toBuf.ready;
	assign cmdReady = state_q == swm_pkg::ST_IDLE && toBuf.ready;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			overdrive_q <= 1'b0;
		end else if (take && cmdOp == swm_pkg::CMD_SPEED) begin
			overdrive_q <= cmdBit;
		end else if (take && cmdOp == swm_pkg::CMD_RESET && !overdrive_q) begin
			overdrive_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= swm_pkg::ST_IDLE;
			cnt_q      <= 16'h0;
			lowLen_q   <= 16'h0;
			slotLen_q  <= 16'h0;
			sampleAt_q <= 16'h0;
			isReset_q  <= 1'b0;
			doSample_q <= 1'b0;
		end else begin
			case (state_q)
				swm_pkg::ST_IDLE: begin
					cnt_q <= 16'h0;
					if (take && cmdOp == swm_pkg::CMD_RESET) begin
						state_q    <= swm_pkg::ST_LOW;
						isReset_q  <= 1'b1;
						doSample_q <= 1'b1;
						lowLen_q   <= overdrive_q ? cyc(swm_pkg::OD_RST_LOW_US) : 16'(RST_LOW_CYC);
						slotLen_q  <= overdrive_q ? cyc(swm_pkg::OD_RST_HIGH_US)
							: 16'(RST_HIGH_CYC);
						sampleAt_q <= overdrive_q ? cyc(swm_pkg::OD_PRES_WIN_US)
							: cyc(swm_pkg::PRES_WIN_US);
					end else if (take && cmdOp != swm_pkg::CMD_SPEED) begin
						state_q    <= swm_pkg::ST_LOW;
						isReset_q  <= 1'b0;
						doSample_q <= cmdOp == swm_pkg::CMD_READ;
						if (cmdOp == swm_pkg::CMD_READ) begin
							lowLen_q <= overdrive_q ? cyc(swm_pkg::OD_RD_LOW_US)
								: cyc(swm_pkg::RD_LOW_US);
						end else if (cmdBit) begin
							lowLen_q <= overdrive_q ? cyc(swm_pkg::OD_W1_LOW_US)
								: cyc(swm_pkg::W1_LOW_US);
						end else begin
							lowLen_q <= overdrive_q ? cyc(swm_pkg::OD_W0_LOW_US)
								: cyc(swm_pkg::W0_LOW_US);
						end
						slotLen_q  <= overdrive_q ? cyc(swm_pkg::OD_SLOT_US)
							: cyc(swm_pkg::SLOT_US);
						// Sample point is measured from the falling edge, inside the valid window.
						sampleAt_q <= overdrive_q ? 16'(swm_pkg::OD_RD_SAMPLE_CYC)
							: cyc(swm_pkg::RD_SAMPLE_US);
					end
				end
				swm_pkg::ST_LOW: begin
					cnt_q <= cnt_q + 16'h1;
					if (cnt_q == lowLen_q - 16'h1) begin
						state_q <= swm_pkg::ST_HIGH;
						cnt_q   <= 16'h0;
					end
				end
				swm_pkg::ST_HIGH: begin
					cnt_q <= cnt_q + 16'h1;
					// For a slot the count covers the remainder after the low phase.
					if (cnt_q >= slotLen_q - (isReset_q ? 16'h1 : lowLen_q + 16'h1)) begin
						state_q <= swm_pkg::ST_REC;
						cnt_q   <= 16'h0;
					end
				end
				swm_pkg::ST_REC: begin
					cnt_q <= cnt_q + 16'h1;
					if (cnt_q == 16'(swm_pkg::REC_CYC - 1)) state_q <= swm_pkg::ST_IDLE;
				end
				default: state_q <= swm_pkg::ST_IDLE;
			endcase
		end
	end

	// Sampling the bit or presence; synchroniser lag is 4 cycles, well inside windows.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sampled_q <= 1'b1;
		end else if (state_q == swm_pkg::ST_LOW && cnt_q == 16'h0) begin
			sampled_q <= 1'b1;
		end else if (state_q == swm_pkg::ST_HIGH && doSample_q
			&& cnt_q == sampleAt_q - (isReset_q ? 16'h0 : lowLen_q)) begin
			sampled_q <= lineS_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resVld_q  <= 1'b0;
			resData_q <= 2'h0;
		end else begin
			resVld_q <= state_q == swm_pkg::ST_REC && cnt_q == 16'h0 && doSample_q;
			if (state_q == swm_pkg::ST_REC && cnt_q == 16'h0) begin
				resData_q <= {isReset_q & ~sampled_q, ~isReset_q & sampled_q};
			end
		end
	end

	// Pin is open drain: only ever driven low, otherwise released high to the pull-up.
	assign lineOut = 1'b0;
	assign lineOe  = state_q == swm_pkg::ST_LOW;
	assign overdrive = overdrive_q;

	assign toBuf.valid = resVld_q;
	assign toBuf.data  = resData_q;
	assign rspValid    = fromBuf.valid;
	assign fromBuf.ready = rspReady;
	assign rspBit      = fromBuf.data[0];
	assign rspPresence = fromBuf.data[1];

	swm_skid #(.W(2)) uBuf (
		.clk  (clk),
		.rst_b(rst_b),
		.inp  (toBuf),
		.outp (fromBuf)
	);

	// A reset low is longer than a plain delay may reach, so its length is counted here.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowRun_q <= 16'h0;
		end else begin
			lowRun_q <= lineOe ? lowRun_q + 16'h1 : 16'h0;
		end
	end

	a_low_start: assert property (@(posedge clk) disable iff (!rst_b)
		take && cmdOp != swm_pkg::CMD_SPEED |=> lineOe)
		else $error("Slot did not start low.");
	a_rec_gap: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(lineOe) |-> !lineOe [*8])
		else $error("Recovery too short.");
	a_w1_low: assert property (@(posedge clk) disable iff (!rst_b)
		take && cmdOp == swm_pkg::CMD_WRITE && cmdBit && !overdrive_q
		|=> lineOe [*8] ##143 !lineOe)
		else $error("Write one low wrong.");
	a_od_w1: assert property (@(posedge clk) disable iff (!rst_b)
		take && cmdOp == swm_pkg::CMD_WRITE && cmdBit && overdrive_q
		|=> lineOe ##25 !lineOe)
		else $error("Overdrive write one low wrong.");
	a_rd_low: assert property (@(posedge clk) disable iff (!rst_b)
		take && cmdOp == swm_pkg::CMD_READ && !overdrive_q
		|=> lineOe ##50 !lineOe)
		else $error("Read low wrong.");
	a_od_rst: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(lineOe) && isReset_q && overdrive_q
		|-> lowRun_q == 16'(swm_pkg::OD_RST_LOW_US * swm_pkg::CLK_MHZ))
		else $error("Overdrive reset low wrong.");
	a_rst_low: assert property (@(posedge clk) disable iff (!rst_b)
		take && cmdOp == swm_pkg::CMD_RESET && !overdrive_q
		|=> lineOe [*8])
		else $error("Reset low too short.");
	a_od_keep: assert property (@(posedge clk) disable iff (!rst_b)
		take && cmdOp == swm_pkg::CMD_RESET && overdrive_q |=> overdrive_q)
		else $error("Short reset dropped overdrive.");
	c_reset: cover property (@(posedge clk) take && cmdOp == swm_pkg::CMD_RESET);
	c_read: cover property (@(posedge clk) take && cmdOp == swm_pkg::CMD_READ);
	c_stall: cover property (@(posedge clk) cmdValid && !toBuf.ready);
endmodule : swm_master

// ### tb/swm_slave_model.sv
// Behavioural slave on the shared line: presence, write sampling, read replies, two speeds.
// Assumes the bench forms the line as a wired-AND and says which bit to return.
`timescale 1ns/1ps
module swm_slave_model (
	input  wire logic clk,
	input  wire logic line,
	input  wire logic present,
	input  wire logic rdMode,
	input  wire logic rdBit,
	input  wire logic odSet,
	output logic      slvLow = 1'b0,
	output logic      odFlag = 1'b0,
	output logic      wrSeen = 1'b0,
	output int        lowLen = 0
);
	int        lowCnt  = 0;
	int        fallCnt = 100000;
	int        presCnt = 100000;
	logic      mLowQ   = 1'b0;
	wire logic mLow    = !line && !slvLow;
	// Counts are in 40 ns cycles; the bench flags the overdrive match in place of ROM traffic.
	always @(posedge clk) begin
		mLowQ <= mLow;
		lowCnt <= mLow ? lowCnt + 1 : 0;
		if (fallCnt < 100000) fallCnt <= fallCnt + 1;
		if (presCnt < 100000) presCnt <= presCnt + 1;
		if (mLow && !mLowQ) fallCnt <= 0;
		if (!mLow && mLowQ) begin
			lowLen <= lowCnt;
			if (lowCnt > (odFlag ? 400 : 3000) && present) presCnt <= 0;
			if (lowCnt >= 11990) odFlag <= 1'b0;
		end
		if (odSet) odFlag <= 1'b1;
		if (fallCnt == (odFlag ? 75 : 750) && !rdMode) wrSeen <= line;
		slvLow <= (presCnt >= (odFlag ? 75 : 750) && presCnt < (odFlag ? 450 : 3750))
			|| (rdMode && !rdBit && fallCnt < (odFlag ? 50 : 375));
	end
endmodule : swm_slave_model

// ### tb/swm_master_tb_top.sv
// Self-checking bench for the single-wire bus master against the behavioural slave.
// Assumes a pull-up on the line, so it reads high unless some party pulls it low.
`timescale 1ns/1ps
module swm_master_tb_top;
	logic       clk = 1'b0;
	logic       rst_b, cmdValid, rspReady, cmdBit, present, rdMode, rdBit, odSet, b0, b1;
	logic [1:0] cmdOp;
	wire logic  cmdReady, rspValid, rspBit, rspPresence, overdrive, lineOe, slvLow, odFlag;
	wire logic  wrSeen, lineOut;
	wire logic  line = ~(lineOe | slvLow);
	int         lowLen, errors = 0, checksDone = 0;
	swm_master swm_master_inst (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdOp(cmdOp), .cmdBit(cmdBit), .rspValid(rspValid),
		.rspReady(rspReady), .rspBit(rspBit), .rspPresence(rspPresence),
		.overdrive(overdrive), .lineIn(line), .lineOut(lineOut), .lineOe(lineOe));
	swm_slave_model swm_slave_model_inst (.clk(clk), .line(line), .present(present),
		.rdMode(rdMode), .rdBit(rdBit), .odSet(odSet), .slvLow(slvLow), .odFlag(odFlag),
		.wrSeen(wrSeen), .lowLen(lowLen));
	initial forever #20 clk = ~clk;
	task automatic chk(input string nm, input logic seen, input logic exp);
		checksDone++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// Bounded waits keep a stuck handshake from hanging the run before the watchdog.
	task automatic cmd(input logic [1:0] op, input logic bv);
		int n;
		n = 0;
		@(posedge clk);
		cmdOp <= op;
		cmdBit <= bv;
		cmdValid <= 1'b1;
		do @(posedge clk); while (cmdReady !== 1'b1 && ++n < 40000);
		if (n >= 40000) errors++;
		cmdValid <= 1'b0;
	endtask : cmd
	task automatic settle;
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		while (cmdReady !== 1'b1 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40000) errors++;
	endtask : settle
	task automatic take(input string nm, input logic isPres, input logic exp);
		int n;
		n = 0;
		@(posedge clk);
		rspReady <= 1'b1;
		do @(posedge clk); while (rspValid !== 1'b1 && ++n < 40000);
		if (n >= 40000) errors++;
		chk(nm, isPres ? rspPresence : rspBit, exp);
		rspReady <= 1'b0;
	endtask : take
	// One write or read slot; writes are checked at the slave and by their low time.
	task automatic slot(input logic rd, input logic bv);
		logic od;
		od = overdrive;
		rdMode <= rd;
		rdBit <= bv;
		cmd(rd ? swm_pkg::CMD_READ : swm_pkg::CMD_WRITE, bv);
		if (rd) take("rspBit", 1'b0, bv);
		else begin
			settle();
			chk("wrSeen", wrSeen, bv);
			chk("lowLen", bv ? (lowLen >= 25 && lowLen <= (od ? 50 : 375))
				: (lowLen >= (od ? 150 : 1500) && lowLen <= (od ? 400 : 3000)), 1'b1);
		end
	endtask : slot
	task automatic rst_seq(input logic pres, input logic expOd);
		present <= pres;
		rdMode <= 1'b0;
		cmd(swm_pkg::CMD_RESET, 1'b0);
		take("rspPresence", 1'b1, pres);
		chk("resetLow", lowLen >= (expOd ? 1200 : 12000) && lowLen <= (expOd ? 2000 : 24000),
			1'b1);
		chk("odFlag", odFlag, expOd);
		$display("reset sequence done");
	endtask : rst_seq
	task automatic bits;
		for (int i = 0; i < 4; i++) slot(i[1], i[0]);
		repeat (4) slot(1'($urandom), 1'($urandom));
		$display("slot test done");
	endtask : bits
	initial begin
		#4000000;
		errors++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h0444));
		{cmdValid, rspReady, cmdBit, present, rdMode, rdBit, odSet} = 7'h00;
		cmdOp = 2'h0;
		rst_b = 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		chk("lineOe", lineOe, 1'b0);
		chk("lineOut", lineOut, 1'b0);
		chk("overdrive", overdrive, 1'b0);
		rst_seq(1'b1, 1'b0);
		bits();
		cmd(swm_pkg::CMD_SPEED, 1'b1);
		odSet <= 1'b1;
		@(posedge clk);
		odSet <= 1'b0;
		settle();
		chk("overdrive", overdrive, 1'b1);
		rst_seq(1'b1, 1'b1);
		bits();
		b0 = 1'($urandom);
		b1 = ~b0;
		rdMode <= 1'b1;
		rdBit <= b0;
		cmd(swm_pkg::CMD_READ, 1'b0);
		settle();
		rdBit <= b1;
		cmd(swm_pkg::CMD_READ, 1'b0);
		repeat (600) @(posedge clk);
		chk("cmdReady", cmdReady, 1'b0);
		take("rspBit", 1'b0, b0);
		take("rspBit", 1'b0, b1);
		$display("buffer test done");
		cmd(swm_pkg::CMD_SPEED, 1'b0);
		settle();
		chk("overdrive", overdrive, 1'b0);
		rst_seq(1'b0, 1'b0);
		give_verdict();
	end
endmodule : swm_master_tb_top
